// *** core/ethernet_power_state_manager.sv ***
// Purpose: power-state manager, D0/D1/D2, wake events, ready flag
// Assumes: aclk always on; gating outputs stop the other clocks
// Notes: registers over AXI4-Lite; wake inputs are levels
// Contract
// - one normal state D0, sleep D1, D2
// - sleep clears ready; only control register readable
// - writes ignored until first read after reset/wake
// - byte test write wakes, select returns D0
// - select 01 enters D1, PHY clocks stay
// - D1 enables frame and magic detection
// - D1 frame wake sets status 10, pin
// - any sleep wake sets wake event flag
// - D2 stops MAC, host clocks; PHY detect
// - host sets powerdown then selects 10 for D2
// - carrier present at D2 entry wakes immediately
// - D2 carrier sets status 01, pin
// - wake status readable while asleep
// - registers keep contents across sleep
// - internal clock off only in D2
// - pulse select gives 50ms pulse, else level
// - clearing status or enables releases pin
// - ready within 2ms after wake write
// - flag held while source active, W1C after
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module ethernet_power_state_manager #(
  parameter int RESUME_CYCLES = pwr_pkg::RESUME_CYCLES, // wake to ready
  parameter int PULSE_CYCLES = pwr_pkg::PULSE_CYCLES // pin pulse length
) (
  input wire logic aclk, // 10 MHz clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic wake_frame_det, // wake or magic frame seen
  input wire logic carrier_det, // energy on the line
  output logic wake_pin, // wake event pin, high active
  output logic wake_detect_en, // frame detectors armed
  output logic mac_clk_en, // MAC clock gate
  output logic hbi_clk_en, // host interface clock gate
  output logic phy_clk_en, // PHY clock gate
  output logic internal_clk_en, // internal clock gate
  output logic phy_edpd // PHY in energy-detect powerdown
);
  typedef enum logic [1:0] {ST_D0, ST_D1, ST_D2, ST_WAKING} pstate_e;

  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  pstate_e state_q; // power state
  logic ready_q; // ready flag
  logic read_seen_q; // a read happened since reset or wake
  logic pin_en_q; // wake_pin_enable
  logic pulse_sel_q; // wake_pin_pulse_select
  logic frame_en_q; // wake_frame_enable
  logic energy_en_q; // energy_wake_enable
  logic [1:0] wake_status_q; // wake_status
  logic wake_flag_q; // wake event flag
  logic edpd_bit_q; // phy_energy_powerdown
  localparam int RESUME_W = $clog2(RESUME_CYCLES + 1); // wake timer width
  logic [RESUME_W-1:0] resume_cnt_q; // wake timer
  logic pin_req_q; // last pin request, for edge
  logic [31:0] rdata_q; // read data register

  logic wr_fire; // write taken
  logic rd_fire; // read taken
  logic asleep; // D1 or D2
  logic wr_ok; // write may act
  logic wake_wr; // waking byte test write
  logic src_active; // internal wake interrupt source
  logic pin_req; // pin wants to be active
  logic pulse_active; // pulse timer running
  logic [1:0] sel_now; // select field as read

  assign asleep = (state_q == ST_D1) || (state_q == ST_D2);
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wake_wr = wr_fire && asleep && (s_axi_awaddr == pwr_pkg::BYTE_TEST_OFS);
  assign wr_ok = wr_fire && read_seen_q && ready_q;

  // ---------------------------------------------------------------
  // AXI4-Lite handshakes
  // ---------------------------------------------------------------
  // address and data taken together, one write outstanding
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rdata = rdata_q;

  // write response one cycle after the take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pwr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr[7:2] <= pwr_pkg::PHY_MODE_OFS[7:2])
                     ? pwr_pkg::RESP_OKAY : pwr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign sel_now = (state_q == ST_D1) ? pwr_pkg::SEL_D1 :
                   (state_q == ST_D2) ? pwr_pkg::SEL_D2 : pwr_pkg::SEL_D0;

  // read data; asleep or not ready only the control word answers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= pwr_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= pwr_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      unique case (s_axi_araddr)
        pwr_pkg::PWR_CTRL_OFS: begin
          rdata_q[pwr_pkg::READY_BIT] <= ready_q;
          rdata_q[pwr_pkg::PIN_EN_BIT] <= pin_en_q;
          rdata_q[pwr_pkg::PULSE_SEL_BIT] <= pulse_sel_q;
          rdata_q[pwr_pkg::WSTAT_LSB +: 2] <= wake_status_q;
          rdata_q[pwr_pkg::FRAME_EN_BIT] <= frame_en_q;
          rdata_q[pwr_pkg::SEL_LSB +: 2] <= sel_now;
          rdata_q[pwr_pkg::ENERGY_EN_BIT] <= energy_en_q;
        end
        pwr_pkg::BYTE_TEST_OFS, pwr_pkg::INTERRUPT_STATUS_REG_OFS, pwr_pkg::PHY_MODE_OFS: begin
          if (ready_q) begin
            if (s_axi_araddr == pwr_pkg::INTERRUPT_STATUS_REG_OFS) begin
              rdata_q[pwr_pkg::WAKE_FLAG_BIT] <= wake_flag_q;
            end else if (s_axi_araddr == pwr_pkg::PHY_MODE_OFS) begin
              rdata_q[pwr_pkg::EDPD_BIT] <= edpd_bit_q;
            end
          end
        end
        default: begin // unmapped
          s_axi_rresp <= pwr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // first read after reset or wake unlocks writes
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_seen_q <= 1'b0;
    end else if (wake_wr) begin
      read_seen_q <= 1'b0;
    end else if (rd_fire) begin
      read_seen_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_D0;
      ready_q <= pwr_pkg::READY_RST;
      resume_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_D0: begin
          if (wr_ok && s_axi_awaddr == pwr_pkg::PWR_CTRL_OFS && s_axi_wstrb[1]) begin
            if (s_axi_wdata[pwr_pkg::SEL_LSB +: 2] == pwr_pkg::SEL_D1) begin
              state_q <= ST_D1;
              ready_q <= 1'b0;
            end else if (s_axi_wdata[pwr_pkg::SEL_LSB +: 2] == pwr_pkg::SEL_D2) begin
              state_q <= ST_D2;
              ready_q <= 1'b0;
            end // 00 and reserved 11 stay in D0
          end
        end
        ST_D1, ST_D2: begin
          if (wake_wr) begin
            state_q <= ST_WAKING;
            resume_cnt_q <= '0;
          end
        end
        ST_WAKING: begin
          if (resume_cnt_q == RESUME_W'(RESUME_CYCLES - 1)) begin
            state_q <= ST_D0;
            ready_q <= 1'b1;
          end else begin
            resume_cnt_q <= resume_cnt_q + RESUME_W'(1);
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock gates and PHY condition
  // ---------------------------------------------------------------
  assign mac_clk_en = (state_q != ST_D2);
  assign hbi_clk_en = (state_q != ST_D2);
  assign internal_clk_en = (state_q != ST_D2);
  assign phy_clk_en = (state_q != ST_D2);
  assign phy_edpd = (state_q == ST_D2) || edpd_bit_q;
  assign wake_detect_en = (state_q == ST_D1) || frame_en_q;

  // ---------------------------------------------------------------
  // control fields; kept untouched by sleep
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_en_q <= 1'b0;
      pulse_sel_q <= 1'b0;
      frame_en_q <= 1'b0;
      energy_en_q <= 1'b0;
      edpd_bit_q <= 1'b0;
    end else if (wr_ok) begin
      if (s_axi_awaddr == pwr_pkg::PWR_CTRL_OFS && s_axi_wstrb[0]) begin
        pin_en_q <= s_axi_wdata[pwr_pkg::PIN_EN_BIT];
        pulse_sel_q <= s_axi_wdata[pwr_pkg::PULSE_SEL_BIT];
      end
      if (s_axi_awaddr == pwr_pkg::PWR_CTRL_OFS && s_axi_wstrb[1]) begin
        frame_en_q <= s_axi_wdata[pwr_pkg::FRAME_EN_BIT];
        energy_en_q <= s_axi_wdata[pwr_pkg::ENERGY_EN_BIT];
      end
      if (s_axi_awaddr == pwr_pkg::PHY_MODE_OFS && s_axi_wstrb[1]) begin
        edpd_bit_q <= s_axi_wdata[pwr_pkg::EDPD_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // wake status: detection sets, write of one clears, set wins
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_status_q <= 2'h0;
    end else begin
      if (wr_ok && s_axi_awaddr == pwr_pkg::PWR_CTRL_OFS && s_axi_wstrb[0]) begin
        wake_status_q <= wake_status_q & ~s_axi_wdata[pwr_pkg::WSTAT_LSB +: 2];
      end
      if (state_q == ST_D1 && wake_frame_det) begin
        wake_status_q[1] <= 1'b1;
      end
      if (state_q == ST_D2 && carrier_det) begin
        wake_status_q[0] <= 1'b1; // level seen at entry too
      end
    end
  end

  // ---------------------------------------------------------------
  // wake event flag
  // ---------------------------------------------------------------
  assign src_active = (wake_status_q[1] && frame_en_q) || (wake_status_q[0] && energy_en_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_flag_q <= 1'b0;
    // each sleep state answers only its own wake source; link energy in D1 is no event
    end else if (src_active || (state_q == ST_D1 && wake_frame_det)
                 || (state_q == ST_D2 && carrier_det)) begin
      wake_flag_q <= 1'b1;
    end else if (wr_ok && s_axi_awaddr == pwr_pkg::INTERRUPT_STATUS_REG_OFS && s_axi_wstrb[2]
                 && s_axi_wdata[pwr_pkg::WAKE_FLAG_BIT]) begin
      wake_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // wake pin: level or one pulse per request
  // ---------------------------------------------------------------
  assign pin_req = pin_en_q && src_active;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_req_q <= 1'b0;
    end else begin
      pin_req_q <= pin_req;
    end
  end

  wake_pulse_timer #(
    .CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(pin_req && !pin_req_q),
    .abort(!pin_req),
    .active(pulse_active)
  );

  assign wake_pin = pin_req && (!pulse_sel_q || pulse_active);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence wake_wr_s;
    asleep && wake_wr;
  endsequence
  sequence resume_s;
    (state_q == ST_WAKING) && !ready_q;
  endsequence

  ready_clear_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    asleep |-> !ready_q) else $error("ready set while asleep");
  wake_to_d0_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_wr_s |=> resume_s ##0 (sel_now == pwr_pkg::SEL_D0)) else $error("wake write lost");
  enter_d1_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_D0) && wr_ok && s_axi_awaddr == pwr_pkg::PWR_CTRL_OFS && s_axi_wstrb[1]
    && s_axi_wdata[pwr_pkg::SEL_LSB +: 2] == pwr_pkg::SEL_D1
    |=> (state_q == ST_D1) && !ready_q && phy_clk_en) else $error("no D1 entry");
  write_locked_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !read_seen_q |=> $stable(pin_en_q) && $stable(frame_en_q))
    else $error("write acted before first read");
  frame_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_D1) && wake_frame_det |=> wake_status_q[1] && wake_flag_q)
    else $error("frame wake not recorded");
  d2_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_D2) |-> !mac_clk_en && !hbi_clk_en && !internal_clk_en && phy_edpd)
    else $error("clocks running in D2");
  carrier_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_D2) && carrier_det |=> wake_status_q[0] ##1 wake_flag_q)
    else $error("carrier wake not recorded");
  resume_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    resume_s ##0 (resume_cnt_q == RESUME_W'(RESUME_CYCLES - 1))
    |=> ready_q && (state_q == ST_D0))
    else $error("ready late after wake");
  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    src_active |=> wake_flag_q) else $error("flag dropped with source active");
  pin_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_req && !pulse_sel_q |-> wake_pin) else $error("static pin not driven");
  pin_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pin_req |-> !wake_pin) else $error("pin held without request");
endmodule : ethernet_power_state_manager

// *** core/wake_pulse_timer.sv ***
// Purpose: one-shot timer that shapes the pulsed wake pin
// Assumes: start is a one-cycle pulse on aclk
// Notes: a new start while running restarts the count
`timescale 1ns/1ps
module wake_pulse_timer #(
  parameter int CYCLES = pwr_pkg::PULSE_CYCLES // pulse length in cycles
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic start, // begin a pulse
  input wire logic abort, // end the pulse early
  output logic active // pulse in progress
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q; // cycles left

  // ---------------------------------------------------------------
  // countdown
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || abort) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= W'(CYCLES); // load full width
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign active = (cnt_q != '0);

  // pulse never longer than the load
  pulse_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_q <= W'(CYCLES)) else $error("pulse counter overloaded");
endmodule : wake_pulse_timer

// *** inc/pwr_pkg.sv ***
// Purpose: shared constants of the Ethernet power-state manager
// Assumes: 10 MHz aclk, AXI4-Lite register access, 32-bit words
// Notes: offsets are byte addresses; fields sit in the low half-word, except the wake event flag at bit 17
package pwr_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] PWR_CTRL_OFS = 8'h00; // power_mgmt_control
  localparam logic [7:0] BYTE_TEST_OFS = 8'h04; // wake write target
  localparam logic [7:0] INTERRUPT_STATUS_REG_OFS = 8'h08; // interrupt_status_reg
  localparam logic [7:0] PHY_MODE_OFS = 8'h0C; // phy mode, powerdown bit
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int READY_BIT = 0; // ready flag, read only
  localparam int PIN_EN_BIT = 1; // wake_pin_enable
  localparam int PULSE_SEL_BIT = 3; // wake_pin_pulse_select
  localparam int WSTAT_LSB = 4; // wake_status, two bits
  localparam int FRAME_EN_BIT = 9; // wake_frame_enable
  localparam int SEL_LSB = 12; // power_state_select, two bits
  localparam int ENERGY_EN_BIT = 14; // energy_wake_enable
  localparam int WAKE_FLAG_BIT = 17; // wake event flag in status reg
  localparam int EDPD_BIT = 13; // phy_energy_powerdown
  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_D0 = 2'h0;
  localparam logic [1:0] SEL_D1 = 2'h1;
  localparam logic [1:0] SEL_D2 = 2'h2;
  localparam logic [1:0] WSTAT_ENERGY = 2'h1; // carrier wake
  localparam logic [1:0] WSTAT_FRAME = 2'h2; // frame wake
  localparam logic READY_RST = 1'b1; // ready after reset
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000; // aclk rate
  localparam int RESUME_TIME_US = 2000; // longest wake to ready
  localparam int PULSE_TIME_MS = 50; // wake pin pulse width
  localparam int RESUME_CYCLES = RESUME_TIME_US * (CLK_HZ / 1_000_000);
  localparam int PULSE_CYCLES = PULSE_TIME_MS * (CLK_HZ / 1000);
endpackage : pwr_pkg

// *** verif/host_model.sv ***
// Purpose: host processor model on the AXI4-Lite register bus
// Assumes: caller enters each task just after a rising edge
// Notes: b/r ready stay high; hung rises when a wait runs out
`timescale 1ns/1ps
module host_model (
  input wire logic aclk, // clock
  output logic [7:0] awaddr, // write address
  output logic awvalid, // aw valid
  input wire logic awready, // aw ready
  output logic [31:0] wdata, // write data
  output logic [3:0] wstrb, // byte enables
  output logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // b valid
  output logic bready, // b ready
  output logic [7:0] araddr, // read address
  output logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // r valid
  output logic rready, // r ready
  output logic hung // a wait ran out
);
  // idle bus; answers always accepted
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b1;
    hung = 1'b0;
  end
  // one full word write; aw and w offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!(awready && wready) && n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    if (n >= 50) hung <= 1'b1;
  endtask : wr
  // one word read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    if (n >= 50) hung <= 1'b1;
  endtask : rd
endmodule : host_model

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the power-state manager
// Assumes: shortened resume and pulse counts
// Notes: all bus cycles go through host_model
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------
  // signals, clock, instances
  // ---------------------------------------------------------------
  localparam int RESUME = 8; // shortened wake to ready
  localparam int PULSE = 10; // shortened pin pulse
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic wake_frame_det = 1'b0;
  logic carrier_det = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, hung;
  logic wake_pin, wake_detect_en, mac_clk_en, hbi_clk_en, phy_clk_en, internal_clk_en;
  logic phy_edpd;
  logic [31:0] hi_cnt = 32'h0; // cycles with wake pin high
  int n_errors = 0;
  int samples_checked = 0;
  always #50 aclk = ~aclk; // 10 MHz
  always @(posedge aclk) if (wake_pin === 1'b1) hi_cnt <= hi_cnt + 32'h1;
  ethernet_power_state_manager #(.RESUME_CYCLES(RESUME), .PULSE_CYCLES(PULSE)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wake_frame_det(wake_frame_det), .carrier_det(carrier_det), .wake_pin(wake_pin),
    .wake_detect_en(wake_detect_en), .mac_clk_en(mac_clk_en), .hbi_clk_en(hbi_clk_en),
    .phy_clk_en(phy_clk_en), .internal_clk_en(internal_clk_en), .phy_edpd(phy_edpd));
  host_model host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .hung(hung));
  // ---------------------------------------------------------------
  // compare, bus helpers, verdict
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk({30'h0, r}, {30'h0, pwr_pkg::RESP_OKAY});
  endtask : wrc
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(d, exp);
  endtask : rdc
  // poll control until ready, bounded number of reads
  task automatic wait_ready();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    d = 32'h0;
    while (d[pwr_pkg::READY_BIT] !== 1'b1 && n < 10) begin
      host.rd(pwr_pkg::PWR_CTRL_OFS, d, r);
      n++;
    end
    if (n >= 10) n_errors++;
    if (n >= 10) summarize();
  endtask : wait_ready
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // a bus wait that ran out ends the run
  always @(posedge hung) begin
    n_errors++;
    summarize();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    wrc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_0202); // write before any read
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_0001);
    wrc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_0202);
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_0203);
    host.rd(8'h10, d, r);
    chk({30'h0, r}, {30'h0, pwr_pkg::RESP_SLVERR}); // unmapped read
  endtask : t_reset
  // frame wake from D1 with a static pin
  task automatic t_frame();
    wrc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_1202);
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_1202);
    chk({27'h0, wake_detect_en, phy_clk_en, internal_clk_en, mac_clk_en, wake_pin},
        32'h1E);
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_1202);
    wake_frame_det <= 1'b1;
    @(posedge aclk);
    wake_frame_det <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, wake_pin}, 32'h1);
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_1222);
    wrc(pwr_pkg::BYTE_TEST_OFS, 32'h0);
    wait_ready();
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_0223);
    rdc(pwr_pkg::INTERRUPT_STATUS_REG_OFS, 32'h0002_0000);
    wrc(pwr_pkg::INTERRUPT_STATUS_REG_OFS, 32'h0002_0000);
    rdc(pwr_pkg::INTERRUPT_STATUS_REG_OFS, 32'h0002_0000);
    wrc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_0222);
    chk({31'h0, wake_pin}, 32'h0);
    wrc(pwr_pkg::INTERRUPT_STATUS_REG_OFS, 32'h0002_0000);
    rdc(pwr_pkg::INTERRUPT_STATUS_REG_OFS, 32'h0);
  endtask : t_frame
  // carrier already present at D2 entry, pulsed pin
  task automatic t_energy();
    logic [31:0] hi0; // pin-high count before this scenario
    hi0 = hi_cnt;
    carrier_det <= 1'b1;
    wrc(pwr_pkg::PHY_MODE_OFS, 32'h0000_2000);
    wrc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_400A);
    wrc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_600A);
    chk({27'h0, mac_clk_en, hbi_clk_en, phy_clk_en, internal_clk_en, phy_edpd},
        32'h1);
    repeat (30) @(posedge aclk);
    chk(hi_cnt - hi0, PULSE);
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_601A);
    carrier_det <= 1'b0;
    wrc(pwr_pkg::BYTE_TEST_OFS, 32'hFFFF_FFFF);
    wait_ready();
    wrc(pwr_pkg::PHY_MODE_OFS, 32'h0);
    chk({27'h0, mac_clk_en, hbi_clk_en, phy_clk_en, internal_clk_en, phy_edpd},
        32'h1E);
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_401B);
    wrc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_001A);
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_000B);
  endtask : t_energy
  // reserved select leaves the device in D0
  task automatic t_reserved();
    wrc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_300A);
    rdc(pwr_pkg::PWR_CTRL_OFS, 32'h0000_000B);
    chk({28'h0, mac_clk_en, hbi_clk_en, phy_clk_en, internal_clk_en}, 32'hF);
  endtask : t_reserved
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_frame();
    t_energy();
    t_reserved();
    summarize();
  end
endmodule : tb_top
